// ===== common/wsp_pkg.sv
/*
 * Shared constants and types of the weighing set-point and image logic.
 * Assumes one 25 MHz clock and a word-addressed process image port.
 */
package wsp_pkg;
    // ************************************************
    // Clock and command timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int CMD_TIME_NS = 10000;
    localparam int CMD_BUSY_CYC = CMD_TIME_NS / CLK_PERIOD_NS;
    // ************************************************
    // Process image word addresses
    // ************************************************
    localparam logic [15:0] ADR_CMD = 16'h9c42;
    localparam logic [15:0] ADR_CAL = 16'h9c43;
    localparam logic [15:0] ADR_DZERO = 16'h9c45;
    localparam logic [15:0] ADR_SPAN = 16'h9c47;
    localparam logic [15:0] ADR_CAP = 16'h9c49;
    localparam logic [15:0] ADR_SENS = 16'h9c4b;
    localparam logic [15:0] ADR_RESULT = 16'hb151;
    localparam logic [15:0] ADR_INPUTS = 16'hb152;
    localparam logic [15:0] ADR_GROSS = 16'hb153;
    localparam logic [15:0] ADR_STATUS = 16'hb155;
    localparam logic [15:0] ADR_NET = 16'hb156;
    localparam logic [15:0] ADR_OUTPUTS = 16'hb158;
    // ************************************************
    // Reset values, commands, status fields
    // ************************************************
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [31:0] VAL_RST = 32'h0000_0000;
    localparam logic [15:0] CMD_START = 16'h00d9;
    localparam logic [15:0] CMD_ZERO = 16'h00da;
    localparam logic [15:0] CMD_SEGMENT = 16'h00db;
    localparam logic [15:0] CMD_STORE = 16'h00de;
    localparam int ST_RANGE_LSB = 2;
    localparam int ST_NEAR_ZERO = 5;
    localparam int ST_IN_LSB = 8;
    localparam int ST_OUT_LSB = 10;
    localparam int ST_TARE = 14;
    localparam logic [1:0] RANGE_OVER = 2'h2;
    localparam logic [31:0] ZERO_LIMIT_PCT = 32'h0000_000a;

    typedef enum logic [1:0] {
        RES_IDLE = 2'b00,
        RES_BUSY = 2'b01,
        RES_DONE = 2'b10,
        RES_ERROR = 2'b11
    } wsp_result_e;

    typedef enum logic [2:0] {
        DIV_1 = 3'b000,
        DIV_2 = 3'b001,
        DIV_5 = 3'b010,
        DIV_10 = 3'b011,
        DIV_20 = 3'b100,
        DIV_50 = 3'b101,
        DIV_100 = 3'b110
    } wsp_div_e;

    typedef enum logic [2:0] {
        STAB_OFF = 3'b000,
        STAB_QUARTER = 3'b001,
        STAB_HALF = 3'b010,
        STAB_ONE = 3'b011,
        STAB_TWO = 3'b100
    } wsp_stab_e;

    typedef struct packed {
        logic signed [31:0] low;
        logic signed [31:0] high;
    } wsp_setpoint_s;

    function automatic logic [7:0] div_step(input wsp_div_e d);
        case (d)
            DIV_2: div_step = 8'h02;
            DIV_5: div_step = 8'h05;
            DIV_10: div_step = 8'h0a;
            DIV_20: div_step = 8'h14;
            DIV_50: div_step = 8'h32;
            DIV_100: div_step = 8'h64;
            default: div_step = 8'h01;
        endcase
    endfunction
endpackage

// ===== src/wsp_quant.sv
/*
 * Rounds a signed weight to the nearest multiple of the division.
 * Assumes the division select is steady while the result is used.
 */
module wsp_quant
(
    // Weight in and out
    input wire logic signed [31:0] i_value,
    input wire wsp_pkg::wsp_div_e i_div,
    output logic signed [31:0] o_value
);
    import wsp_pkg::*;

    logic [32:0] mag;
    logic [32:0] sum;
    logic [32:0] rnd;
    logic [32:0] step;

    // Round the magnitude so both signs round symmetrically
    always_comb
    begin
        mag = i_value[31] ? 33'(-i_value) : 33'(i_value);
        step = {25'h0, div_step(i_div)};
        sum = mag + (step >> 1);
        case (i_div)
            DIV_2: rnd = (sum / 33'd2) * 33'd2;
            DIV_5: rnd = (sum / 33'd5) * 33'd5;
            DIV_10: rnd = (sum / 33'd10) * 33'd10;
            DIV_20: rnd = (sum / 33'd20) * 33'd20;
            DIV_50: rnd = (sum / 33'd50) * 33'd50;
            DIV_100: rnd = (sum / 33'd100) * 33'd100;
            default: rnd = mag;
        endcase
        o_value = i_value[31] ? -$signed(rnd[31:0]) : $signed(rnd[31:0]);
    end
endmodule // wsp_quant

// ===== src/wsp_top.sv
/*
 * Weighing transmitter logic: zero handling, division rounding, stability,
 * two hysteresis set points and the island-bus word process image.
 * Assumes raw weight arrives as a same-clock strobe; pins are asynchronous.
 */
// Overview of operation
// - Indicated weight is rounded to a selectable division of 1 to 100.
// - Gross and net indicated values use the same rounding.
// - Zero mode bit 0 enables tracking, bit 1 enables power-up zero.
// - All four zero mode values 0 to 3 are accepted.
// - With both zero functions on, corrections stay within 10% capacity.
// - Stability field selects off, 0.25, 0.5, 1 or 2 divisions.
// - Output 1 follows set point 1, output 2 follows set point 2.
// - Outputs are active high when their set point condition holds.
// - Set points compare against net weight, never gross.
// - Both set points switch with hysteresis.
// - Input words sit at fixed addresses from 45393 to 45400.
// - Image words are 16-bit island-bus words, fieldbus independent.
// - Result word shows idle, busy, done or error as 0 to 3.
module wsp_top
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Measurement from the converter path
    input wire logic i_meas_valid,
    input wire logic signed [31:0] i_raw_weight,
    // Configuration parameters
    input wire wsp_pkg::wsp_div_e i_division,
    input wire logic [1:0] i_zero_mode,
    input wire wsp_pkg::wsp_stab_e i_stability,
    input wire wsp_pkg::wsp_setpoint_s i_setpoint1,
    input wire wsp_pkg::wsp_setpoint_s i_setpoint2,
    // Digital pins
    input wire logic [1:0] i_din,
    output logic [1:0] o_dout,
    output logic o_stable,
    // Process image word port
    input wire logic i_img_wr,
    input wire logic i_img_rd,
    input wire logic [15:0] i_img_addr,
    input wire logic [15:0] i_img_wdata,
    output logic [15:0] o_img_rdata,
    output logic o_img_rvalid
);
    import wsp_pkg::*;

    function automatic logic [31:0] mag32(input logic signed [31:0] v);
        mag32 = v[31] ? 32'(-v) : 32'(v);
    endfunction

    // ************************************************
    // Declarations
    // ************************************************
    logic [15:0] cmd_q;
    logic [31:0] cal_q;
    logic [31:0] dzero_q;
    logic [31:0] span_q;
    logic [31:0] cap_q;
    logic [15:0] sens_q;
    logic [1:0] din_meta_q;
    logic [1:0] din_sync_q;
    logic in1_last_q;
    logic signed [31:0] zero_q;
    logic signed [31:0] tare_q;
    logic tare_done_q;
    logic first_q;
    logic signed [31:0] prev_q;
    logic stable_q;
    logic signed [31:0] gross_ind_q;
    logic signed [31:0] net_ind_q;
    logic [1:0] dout_q;
    logic [15:0] status_q;
    logic [15:0] rdata_q;
    logic rvalid_q;
    wsp_result_e res_q;
    logic [15:0] cnt_q;
    logic cal_open_q;
    logic signed [31:0] offset_raw;
    logic signed [31:0] gross_raw;
    logic signed [31:0] net_raw;
    logic signed [31:0] gross_q;
    logic signed [31:0] net_q;
    logic [39:0] diff4;
    logic [39:0] thr;
    logic [39:0] step40;
    logic [39:0] zero10;
    logic [39:0] track10;
    logic range_ok;
    logic track_ok;
    wsp_setpoint_s sp [2];

    // ************************************************
    // Output image registers
    // ************************************************
    // Controller writes; 32-bit values take high word at the lower address
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cmd_q <= WORD_RST;
            cal_q <= VAL_RST;
            dzero_q <= VAL_RST;
            span_q <= VAL_RST;
            cap_q <= VAL_RST;
            sens_q <= WORD_RST;
        end
        else if (i_img_wr)
        begin
            if (i_img_addr == ADR_CMD)
                cmd_q <= i_img_wdata;
            else if (i_img_addr == ADR_CAL)
                cal_q[31:16] <= i_img_wdata;
            else if (i_img_addr == ADR_CAL + 16'h0001)
                cal_q[15:0] <= i_img_wdata;
            else if (i_img_addr == ADR_DZERO)
                dzero_q[31:16] <= i_img_wdata;
            else if (i_img_addr == ADR_DZERO + 16'h0001)
                dzero_q[15:0] <= i_img_wdata;
            else if (i_img_addr == ADR_SPAN)
                span_q[31:16] <= i_img_wdata;
            else if (i_img_addr == ADR_SPAN + 16'h0001)
                span_q[15:0] <= i_img_wdata;
            else if (i_img_addr == ADR_CAP)
                cap_q[31:16] <= i_img_wdata;
            else if (i_img_addr == ADR_CAP + 16'h0001)
                cap_q[15:0] <= i_img_wdata;
            else if (i_img_addr == ADR_SENS)
                sens_q <= i_img_wdata;
        end
    end

    // ************************************************
    // Pin synchronisers and tare edge
    // ************************************************
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            din_meta_q <= 2'h0;
            din_sync_q <= 2'h0;
            in1_last_q <= 1'b0;
        end
        else
        begin
            din_meta_q <= i_din;
            din_sync_q <= din_meta_q;
            in1_last_q <= din_sync_q[0];
        end
    end

    // ************************************************
    // Zero, gross and net arithmetic
    // ************************************************
    always_comb
    begin
        offset_raw = i_raw_weight + $signed(dzero_q);
        gross_raw = offset_raw - zero_q;
        net_raw = gross_raw - tare_q;
        step40 = {32'h0, div_step(i_division)};
        zero10 = 40'(mag32(offset_raw)) * 40'(ZERO_LIMIT_PCT);
        track10 = 40'(mag32(offset_raw - zero_q + zero_q)) * 40'(ZERO_LIMIT_PCT);
        // Tracking only near empty, and zeroing inside 10% when both functions on
        range_ok = (i_zero_mode != 2'b11)
            || (zero10 <= 40'(cap_q) * 40'd100 / 40'd100);
        track_ok = (40'(mag32(gross_raw)) * 40'd4 < step40)
            && (i_zero_mode != 2'b11 || track10 <= 40'(cap_q));
        diff4 = 40'(mag32(gross_raw - prev_q)) * 40'd4;
        case (i_stability)
            STAB_QUARTER: thr = step40;
            STAB_HALF: thr = step40 * 40'd2;
            STAB_ONE: thr = step40 * 40'd4;
            default: thr = step40 * 40'd8;
        endcase
    end

    // Power-up zero on the first reading, tracking while stable
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            zero_q <= VAL_RST;
            first_q <= 1'b1;
        end
        else if (i_meas_valid)
        begin
            first_q <= 1'b0;
            if (res_q == RES_BUSY && cnt_q == 16'h0 && cmd_q == CMD_ZERO)
                zero_q <= offset_raw;
            else if (first_q && i_zero_mode[1] && range_ok)
                zero_q <= offset_raw;
            else if (!first_q && i_zero_mode[0] && stable_q && track_ok)
                zero_q <= offset_raw;
        end
    end

    // Tare on a rising edge of input 1
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tare_q <= VAL_RST;
            tare_done_q <= 1'b0;
        end
        else if (din_sync_q[0] && !in1_last_q)
        begin
            tare_q <= gross_raw;
            tare_done_q <= 1'b1;
        end
    end

    // ************************************************
    // Rounding and stability
    // ************************************************
    wsp_quant u_quant_gross
    (
        .i_value(gross_raw),
        .i_div(i_division),
        .o_value(gross_q)
    );

    wsp_quant u_quant_net
    (
        .i_value(net_raw),
        .i_div(i_division),
        .o_value(net_q)
    );

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            gross_ind_q <= VAL_RST;
            net_ind_q <= VAL_RST;
            prev_q <= VAL_RST;
            stable_q <= 1'b1;
        end
        else if (i_meas_valid)
        begin
            gross_ind_q <= gross_q;
            net_ind_q <= net_q;
            prev_q <= gross_raw;
            stable_q <= (i_stability == STAB_OFF) || (diff4 <= thr);
        end
    end

    // ************************************************
    // Set points
    // ************************************************
    assign sp[0] = i_setpoint1;
    assign sp[1] = i_setpoint2;

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_setpoint
            // Set wins if limits overlap, so a bad setting cannot chatter
            always_ff @(posedge i_clock or negedge i_rst_n)
            begin
                if (!i_rst_n)
                    dout_q[g] <= 1'b0;
                else if (net_ind_q > sp[g].high)
                    dout_q[g] <= 1'b1;
                else if (net_ind_q < sp[g].low)
                    dout_q[g] <= 1'b0;
            end
        end
    endgenerate

    // ************************************************
    // Command sequencer
    // ************************************************
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            res_q <= RES_IDLE;
            cnt_q <= WORD_RST;
            cal_open_q <= 1'b0;
        end
        else
        begin
            case (res_q)
                RES_IDLE:
                    if (cmd_q == CMD_START || cmd_q == CMD_ZERO
                        || (cal_open_q && (cmd_q == CMD_SEGMENT
                        || cmd_q == CMD_STORE)))
                    begin
                        res_q <= RES_BUSY;
                        cnt_q <= 16'(CMD_BUSY_CYC);
                    end
                    else if (cmd_q != WORD_RST)
                        res_q <= RES_ERROR;
                RES_BUSY:
                    if (cmd_q == WORD_RST)
                        res_q <= RES_ERROR;
                    else if (cnt_q != 16'h0)
                        cnt_q <= cnt_q - 16'h0001;
                    else
                    begin
                        res_q <= RES_DONE;
                        if (cmd_q == CMD_START)
                            cal_open_q <= 1'b1;
                        else if (cmd_q == CMD_STORE)
                            cal_open_q <= 1'b0;
                    end
                default:
                    // Waits for the zero word before the next command
                    if (cmd_q == WORD_RST)
                        res_q <= RES_IDLE;
            endcase
        end
    end

    // ************************************************
    // Input image
    // ************************************************
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            status_q <= WORD_RST;
        else
        begin
            status_q <= WORD_RST;
            if (40'(mag32(gross_ind_q)) > 40'(cap_q))
                status_q[ST_RANGE_LSB +: 2] <= RANGE_OVER;
            status_q[ST_NEAR_ZERO] <=
                40'(mag32(gross_raw)) * 40'd4 < step40;
            status_q[ST_IN_LSB +: 2] <= din_sync_q;
            status_q[ST_OUT_LSB +: 2] <= dout_q;
            status_q[ST_TARE] <= tare_done_q;
        end
    end

    // Reads answer one cycle later; unmapped words read as zero
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rdata_q <= WORD_RST;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= i_img_rd;
            if (!i_img_rd)
                rdata_q <= WORD_RST;
            else if (i_img_addr == ADR_RESULT)
                rdata_q <= {14'h0, res_q};
            else if (i_img_addr == ADR_INPUTS)
                rdata_q <= {14'h0, din_sync_q};
            else if (i_img_addr == ADR_GROSS)
                rdata_q <= gross_ind_q[31:16];
            else if (i_img_addr == ADR_GROSS + 16'h0001)
                rdata_q <= gross_ind_q[15:0];
            else if (i_img_addr == ADR_STATUS)
                rdata_q <= status_q;
            else if (i_img_addr == ADR_NET)
                rdata_q <= net_ind_q[31:16];
            else if (i_img_addr == ADR_NET + 16'h0001)
                rdata_q <= net_ind_q[15:0];
            else if (i_img_addr == ADR_OUTPUTS)
                rdata_q <= {14'h0, dout_q};
            else if (i_img_addr == ADR_CMD)
                rdata_q <= cmd_q;
            else if (i_img_addr == ADR_SENS)
                rdata_q <= sens_q;
            else if (i_img_addr == ADR_SPAN)
                rdata_q <= span_q[31:16];
            else if (i_img_addr == ADR_CAL)
                rdata_q <= cal_q[31:16];
            else
                rdata_q <= WORD_RST;
        end
    end

    assign o_dout = dout_q;
    assign o_stable = stable_q;
    assign o_img_rdata = rdata_q;
    assign o_img_rvalid = rvalid_q;

    // ************************************************
    // Assertions
    // ************************************************
    property p_sp_set;
        @(posedge i_clock) disable iff (!i_rst_n)
        net_ind_q > sp[0].high |=> dout_q[0];
    endproperty
    a_sp_set: assert property (p_sp_set)
        else $error("output 1 not set above high value");

    property p_sp_hold;
        @(posedge i_clock) disable iff (!i_rst_n)
        dout_q[1] && net_ind_q >= sp[1].low |=> dout_q[1];
    endproperty
    a_sp_hold: assert property (p_sp_hold)
        else $error("output 2 dropped inside hysteresis band");

    property p_sp_clear;
        @(posedge i_clock) disable iff (!i_rst_n)
        net_ind_q < sp[0].low && net_ind_q <= sp[0].high |=> !dout_q[0];
    endproperty
    a_sp_clear: assert property (p_sp_clear)
        else $error("output 1 not cleared below low value");

    property p_quant_ten;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_meas_valid && i_division == DIV_10 |=> gross_ind_q % 10 == 0;
    endproperty
    a_quant_ten: assert property (p_quant_ten)
        else $error("gross not a multiple of ten");

    property p_quant_net;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_meas_valid && i_division == DIV_2 |=> !net_ind_q[0];
    endproperty
    a_quant_net: assert property (p_quant_net)
        else $error("net not a multiple of two");

    property p_stab_off;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_meas_valid && i_stability == STAB_OFF |=> stable_q;
    endproperty
    a_stab_off: assert property (p_stab_off)
        else $error("not stable with motion detection off");

    property p_busy_end;
        @(posedge i_clock) disable iff (!i_rst_n)
        res_q == RES_BUSY && cnt_q == 16'h0 && cmd_q != WORD_RST
        |=> res_q == RES_DONE;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("command did not finish");

    property p_idle_back;
        @(posedge i_clock) disable iff (!i_rst_n)
        res_q == RES_DONE && cmd_q == WORD_RST |=> res_q == RES_IDLE;
    endproperty
    a_idle_back: assert property (p_idle_back)
        else $error("result not idle after zero command word");

    property p_read_result;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_img_rd && i_img_addr == ADR_RESULT
        |=> o_img_rvalid && o_img_rdata == {14'h0, $past(res_q)};
    endproperty
    a_read_result: assert property (p_read_result)
        else $error("result word read wrong");
endmodule // wsp_top

// ===== tb/wsp_nim_model.sv
/*
 * Behavioural island-bus interface module facing the process image port.
 * Assumes the device takes requests on the rising edge of i_clock.
 */
module wsp_nim_model
(
    // Clock
    input wire logic i_clock,
    // Image port requests
    output logic o_wr,
    output logic o_rd,
    output logic [15:0] o_addr,
    output logic [15:0] o_wdata,
    // Image port answers
    input wire logic [15:0] i_rdata,
    input wire logic i_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    import wsp_pkg::*;

    initial
    begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 16'h0000;
        o_wdata = 16'h0000;
    end

    task automatic wr_word(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_clock);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clock);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask

    // Missing answer returns unknown so the caller's compare fails
    task automatic rd_word(input logic [15:0] a, output logic [15:0] d);
        @(posedge i_clock);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clock);
        o_rd <= 1'b0;
        o_addr <= ~a;
        @(posedge i_clock);
        d = i_rvalid ? i_rdata : 16'hxxxx;
    endtask

    // Issue, wait on the result, then clear the command word
    task automatic command(input logic [15:0] c, output logic [15:0] first,
                           output logic [15:0] last);
        int n;
        n = 0;
        wr_word(ADR_CMD, c);
        repeat (2) @(posedge i_clock);
        rd_word(ADR_RESULT, first);
        last = first;
        while (last === 16'h0001 && n < 400)
        begin
            rd_word(ADR_RESULT, last);
            n++;
        end
        wr_word(ADR_CMD, 16'h0000);
        repeat (3) @(posedge i_clock);
    endtask
endmodule // wsp_nim_model

// ===== tb/tb_wsp_top.sv
/*
 * Self-checking bench of wsp_top: rounding, stability, set points,
 * command result word. Image port is driven by the partner model.
 */
module tb_wsp_top;
    timeunit 1ns;
    timeprecision 1ps;
    import wsp_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic meas_valid = 1'b0;
    logic signed [31:0] raw_weight = 32'sh0;
    wsp_div_e division = DIV_1;
    wsp_stab_e stability = STAB_OFF;
    wsp_setpoint_s sp1 = '0;
    wsp_setpoint_s sp2 = '0;
    logic [1:0] din = 2'h0;
    logic [1:0] zero_mode = 2'h0;
    logic [1:0] dout;
    logic stable, img_wr, img_rd, img_rvalid;
    logic [15:0] img_addr, img_wdata, img_rdata, w_hi, w_lo;
    int errors = 0;
    int compares = 0;

    always #20 i_clock = ~i_clock;

    wsp_top dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_meas_valid(meas_valid), .i_raw_weight(raw_weight),
        .i_division(division), .i_zero_mode(zero_mode),
        .i_stability(stability),
        .i_setpoint1(sp1), .i_setpoint2(sp2), .i_din(din), .o_dout(dout),
        .o_stable(stable), .i_img_wr(img_wr), .i_img_rd(img_rd),
        .i_img_addr(img_addr), .i_img_wdata(img_wdata),
        .o_img_rdata(img_rdata), .o_img_rvalid(img_rvalid));

    wsp_nim_model nim (.i_clock(i_clock), .o_wr(img_wr), .o_rd(img_rd),
        .o_addr(img_addr), .o_wdata(img_wdata), .i_rdata(img_rdata),
        .i_rvalid(img_rvalid));

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("Counts: errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic meas(input logic signed [31:0] w);
        @(posedge i_clock);
        meas_valid <= 1'b1;
        raw_weight <= w;
        @(posedge i_clock);
        meas_valid <= 1'b0;
        repeat (3) @(posedge i_clock);
    endtask

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_div;
        logic [31:0] exp [7] = '{32'h0000_04d6, 32'h0000_04d6, 32'h0000_04d8,
            32'h0000_04d8, 32'h0000_04d8, 32'h0000_04e2, 32'h0000_04b0};
        for (int i = 0; i < 7; i++)
        begin
            division <= wsp_div_e'(i);
            meas(32'sh0000_04d6);
            nim.rd_word(ADR_GROSS, w_hi);
            nim.rd_word(ADR_GROSS + 16'h0001, w_lo);
            check({w_hi, w_lo}, exp[i], "gross rounding");
            nim.rd_word(ADR_NET, w_hi);
            nim.rd_word(ADR_NET + 16'h0001, w_lo);
            check({w_hi, w_lo}, exp[i], "net rounding");
        end
        $display("test division done");
    endtask

    // Each step moves by one division of ten counts
    task automatic t_stab;
        logic exp [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
        division <= DIV_10;
        meas(32'sh0000_03e8);
        for (int k = 0; k < 5; k++)
        begin
            stability <= wsp_stab_e'(k);
            meas(32'sh0000_03f2 + 32'sh0000_000a * k);
            check({31'h0, stable}, {31'h0, exp[k]}, "stable flag");
        end
        stability <= STAB_OFF;
        $display("test stability done");
    endtask

    // Tare first so gross is far above every threshold while net is not
    task automatic t_setpoint;
        logic signed [31:0] net [6] = '{32'sh32, 32'shfa, 32'sh96, 32'sh32,
            32'sh5dc, 32'sh9c4};
        logic [1:0] exp [6] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h1, 2'h3};
        division <= DIV_1;
        sp1 <= '{low: 32'sh64, high: 32'shc8};
        sp2 <= '{low: 32'sh3e8, high: 32'sh7d0};
        meas(32'sh0000_1388);
        din <= 2'h1;
        repeat (4) @(posedge i_clock);
        din <= 2'h0;
        repeat (4) @(posedge i_clock);
        for (int i = 0; i < 6; i++)
        begin
            meas(32'sh0000_1388 + net[i]);
            check({30'h0, dout}, {30'h0, exp[i]}, "set point outputs");
        end
        nim.rd_word(ADR_OUTPUTS, w_lo);
        check({16'h0, w_lo}, 32'h0000_0003, "output word");
        nim.rd_word(ADR_STATUS, w_lo);
        check({16'h0, w_lo}, 32'h0000_4c08, "status word");
        $display("test set points done");
    endtask

    task automatic t_cmd;
        logic [15:0] first, last;
        nim.command(CMD_SEGMENT, first, last);
        check({16'h0, last}, 32'h0000_0003, "segment before start");
        nim.command(CMD_START, first, last);
        check({16'h0, first}, 32'h0000_0001, "start busy");
        check({16'h0, last}, 32'h0000_0002, "start done");
        nim.command(CMD_ZERO, first, last);
        check({16'h0, last}, 32'h0000_0002, "zero done");
        nim.command(CMD_SEGMENT, first, last);
        check({16'h0, last}, 32'h0000_0002, "segment done");
        nim.command(CMD_STORE, first, last);
        check({16'h0, last}, 32'h0000_0002, "store done");
        nim.command(CMD_SEGMENT, first, last);
        check({16'h0, last}, 32'h0000_0003, "segment after store");
        nim.rd_word(ADR_RESULT, last);
        check({16'h0, last}, 32'h0000_0000, "result idle");
        nim.rd_word(16'h1234, last);
        check({16'h0, last}, 32'h0000_0000, "unmapped read");
        $display("test command done");
    endtask

    // Zero is taken at the first reading, so the second one shows it
    task automatic t_zero(input logic [1:0] mode,
                          input logic signed [31:0] w,
                          input logic [31:0] exp);
        zero_mode <= mode;
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'b1;
        nim.wr_word(ADR_CAP, 16'h0000);
        nim.wr_word(ADR_CAP + 16'h0001, 16'h2710);
        meas(w);
        meas(w);
        nim.rd_word(ADR_GROSS, w_hi);
        nim.rd_word(ADR_GROSS + 16'h0001, w_lo);
        check({w_hi, w_lo}, exp, "power-up zero");
        $display("test zero mode done");
    endtask

    initial
    begin
        #(40 * 20000);
        errors++;
        end_of_test;
    end

    initial
    begin
        repeat (4) @(posedge i_clock);
        check({31'h0, stable}, 32'h1, "stable in reset");
        check({30'h0, dout}, 32'h0, "outputs in reset");
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        t_div;
        t_stab;
        t_setpoint;
        t_cmd;
        t_zero(2'h2, 32'sh1f4, 32'h0000_0000);
        t_zero(2'h1, 32'sh1f4, 32'h0000_01f4);
        t_zero(2'h3, 32'sh1f4, 32'h0000_0000);
        t_zero(2'h3, 32'sh7d0, 32'h0000_07d0);
        end_of_test;
    end
endmodule // tb_wsp_top
